// file: hdl/eeprom_slave.sv
// two-wire serial eeprom slave: link engine, address counter and array
`timescale 1ns/1ps
module eeprom_slave
    import eeprom_pkg::*;
#(
    parameter int WRITE_CYCLES = SELF_TIMED_WRITE_CYCLES
)(
    // system clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // two-wire link, clock domain of its own
    input  wire logic linkClock,
    input  wire logic dataIn,
    output logic      dataOut,
    output logic      dataOe,
    // protection and status
    input  wire logic writeProtect,
    output logic      writeBusy,
    output logic      standby
);
    // ---------------- link clock domain ----------------
    link_state_e state;
    link_state_e next_state;
    logic [2:0]        bitCount;
    logic [7:0]        shiftIn;
    logic [7:0]        shiftOut;
    logic              readMode;
    logic              matched;
    logic [ADDR_W-1:0] wordAddr;
    logic              dataByteDone;
    logic              startSeen;
    logic              stopSeen;
    logic              stopToggle;
    logic              busyLink;
    logic              protLink;
    logic [7:0]        memory [DEPTH];
    logic [7:0]        fullByte;
    logic              devMatch;

    // start/stop detection: data edges while clock high
    logic startFlag;
    logic stopFlag;
    always_ff @(negedge dataIn or negedge rst_n) begin
        if (!rst_n)
            startFlag <= 1'b0;
        else if (linkClock)
            startFlag <= ~startFlag;
    end
    // the clock stands high after a stop, so the write hand-over is taken at the stop edge itself
    always_ff @(posedge dataIn or negedge rst_n) begin
        if (!rst_n) begin
            stopFlag   <= 1'b0;
            stopToggle <= 1'b0;
        end else if (linkClock) begin
            stopFlag <= ~stopFlag;
            if (dataByteDone && !protLink)
                stopToggle <= ~stopToggle;
        end
    end

    logic startSeenPrev;
    logic stopSeenPrev;
    always_ff @(posedge linkClock or negedge rst_n) begin
        if (!rst_n) begin
            startSeenPrev <= 1'b0;
            stopSeenPrev  <= 1'b0;
        end else begin
            startSeenPrev <= startFlag;
            stopSeenPrev  <= stopFlag;
        end
    end
    assign startSeen = startFlag != startSeenPrev;
    assign stopSeen  = stopFlag != stopSeenPrev;

    function automatic logic match_addr(input logic [7:0] b);
        logic [2:0] zeroMask;
        zeroMask = 3'h7 >> PAGE_SEL_BITS;
        match_addr = (b[7:4] == DEVICE_TYPE) && ((b[3:1] & zeroMask) == 3'h0);
    endfunction

    assign fullByte = {shiftIn[6:0], dataIn};
    assign devMatch = match_addr(fullByte) && !busyLink;

    // state machine advances on rising clock, sampling data
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE:      next_state = ST_IDLE;
            ST_DEV:       if (bitCount == BIT_COUNT_LAST) next_state = devMatch ? ST_DEV_ACK : ST_IDLE;
            ST_DEV_ACK:   next_state = readMode ? ST_RDATA : ST_WADDR;
            ST_WADDR:     if (bitCount == BIT_COUNT_LAST) next_state = ST_WADDR_ACK;
            ST_WADDR_ACK: next_state = ST_WDATA;
            ST_WDATA:     if (bitCount == BIT_COUNT_LAST) next_state = ST_WDATA_ACK;
            ST_WDATA_ACK: next_state = ST_WDATA;
            ST_RDATA:     if (bitCount == BIT_COUNT_LAST) next_state = ST_RACK;
            ST_RACK:      next_state = dataIn ? ST_IDLE : ST_RDATA;
            default:      next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge linkClock or negedge rst_n) begin
        if (!rst_n) begin
            state    <= ST_IDLE;
            bitCount <= 3'h0;
            shiftIn  <= 8'h0;
            readMode <= 1'b0;
        end else if (startSeen) begin
            state    <= ST_DEV;
            bitCount <= 3'h1;
            shiftIn  <= {7'h0, dataIn};
        end else if (stopSeen) begin
            state    <= ST_IDLE;
            bitCount <= 3'h0;
        end else begin
            state    <= next_state;
            shiftIn  <= fullByte;
            bitCount <= (next_state != state) ? 3'h0 : bitCount + 3'h1;
            if (state == ST_DEV && bitCount == BIT_COUNT_LAST)
                readMode <= dataIn;
        end
    end

    // address counter and array writes, link domain
    always_ff @(posedge linkClock or negedge rst_n) begin
        if (!rst_n) begin
            wordAddr     <= ADDR_RESET;
            dataByteDone <= 1'b0;
        end else begin
            if (startSeen || stopSeen)
                dataByteDone <= 1'b0;
            if (state == ST_DEV && bitCount == BIT_COUNT_LAST && devMatch && PAGE_SEL_BITS > 0)
                wordAddr[ADDR_W-1:8] <= fullByte[PAGE_SEL_BITS:1];
            if (state == ST_WADDR && bitCount == BIT_COUNT_LAST)
                wordAddr[7:0] <= fullByte;
            if (state == ST_WDATA && bitCount == BIT_COUNT_LAST) begin
                if (!protLink)
                    memory[wordAddr] <= fullByte;
                wordAddr[PAGE_BITS-1:0] <= wordAddr[PAGE_BITS-1:0] + 1'b1;
                dataByteDone <= 1'b1;
            end
            // a stop may follow the first bit of the next byte, so clear on the second
            if (state == ST_WDATA && bitCount == 3'h1)
                dataByteDone <= 1'b0;
            if (state == ST_RDATA && bitCount == BIT_COUNT_LAST)
                wordAddr <= wordAddr + 1'b1;
        end
    end

    // outgoing bits change on falling clock
    always_ff @(negedge linkClock or negedge rst_n) begin
        if (!rst_n) begin
            dataOut  <= 1'b0;
            dataOe   <= 1'b0;
            shiftOut <= 8'h0;
        end else begin
            dataOut <= 1'b0;
            if (state == ST_DEV_ACK || state == ST_WADDR_ACK || state == ST_WDATA_ACK) begin
                dataOe <= 1'b1;
            end else if (state == ST_RDATA && bitCount == 3'h0) begin
                // first bit of a byte, after the acknowledge slot has passed
                shiftOut <= {memory[wordAddr][6:0], 1'b0};
                dataOe   <= ~memory[wordAddr][7];
            end else if (state == ST_RDATA) begin
                dataOe   <= ~shiftOut[7];
                shiftOut <= {shiftOut[6:0], 1'b0};
            end else begin
                dataOe <= 1'b0;
            end
        end
    end

    // protection and busy seen in the link domain via synchronisers
    level_sync u_prot (
        .clock (linkClock),
        .rst_n (rst_n),
        .in    (writeProtect),
        .out   (protLink)
    );
    level_sync u_busy (
        .clock (linkClock),
        .rst_n (rst_n),
        .in    (writeBusy),
        .out   (busyLink)
    );

    // ---------------- system clock domain ----------------
    logic [2:0] stopSync;
    logic       stopEvent;
    logic       linkIdle;
    logic       activeSync;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            stopSync <= 3'h0;
        else
            stopSync <= {stopSync[1:0], stopToggle};
    end
    assign stopEvent = stopSync[2] ^ stopSync[1];
    // a pending stop counts as idle: the clock stands still until the next frame
    assign linkIdle  = (state == ST_IDLE || stopSeen) && !startSeen;

    // activity is synchronised so the reset value of the synchroniser means idle
    level_sync u_idle (
        .clock (clock),
        .rst_n (rst_n),
        .in    (!linkIdle),
        .out   (activeSync)
    );

    logic timerBusy;
    write_timer #(
        .CYCLES (WRITE_CYCLES)
    ) u_timer (
        .clock (clock),
        .rst_n (rst_n),
        .start (stopEvent),
        .busy  (timerBusy)
    );

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            writeBusy <= 1'b0;
            standby   <= 1'b1;
        end else begin
            writeBusy <= timerBusy | stopEvent;
            standby   <= !activeSync && !timerBusy && !stopEvent;
        end
    end

    standbyBusy_a: assert property (@(posedge clock) disable iff (!rst_n)
        writeBusy |-> !standby)
        else $error("standby while writing");
    busyStart_a: assert property (@(posedge clock) disable iff (!rst_n)
        stopEvent |=> writeBusy)
        else $error("write cycle not started by stop");
    noAckBusy_a: assert property (@(posedge linkClock) disable iff (!rst_n)
        (state == ST_DEV && bitCount == BIT_COUNT_LAST && busyLink) |=> state == ST_IDLE)
        else $error("acknowledged while write cycle busy");
    ackDrive_a: assert property (@(posedge linkClock) disable iff (!rst_n)
        (state == ST_WADDR && bitCount == BIT_COUNT_LAST) |=> state == ST_WADDR_ACK ##1 state == ST_WDATA)
        else $error("word address not acknowledged");
    pageWrap_a: assert property (@(posedge linkClock) disable iff (!rst_n)
        (state == ST_WDATA && bitCount == BIT_COUNT_LAST && !startSeen && !stopSeen)
        |=> wordAddr[ADDR_W-1:PAGE_BITS] == $past(wordAddr[ADDR_W-1:PAGE_BITS]))
        else $error("write address left its page");
    readInc_a: assert property (@(posedge linkClock) disable iff (!rst_n)
        (state == ST_RDATA && bitCount == BIT_COUNT_LAST && !startSeen && !stopSeen)
        |=> wordAddr == $past(wordAddr) + 1'b1)
        else $error("read address did not advance");
    mismatch_a: assert property (@(posedge linkClock) disable iff (!rst_n)
        (state == ST_DEV && bitCount == BIT_COUNT_LAST && !startSeen && !stopSeen && !devMatch)
        |=> state == ST_IDLE)
        else $error("mismatched address not ignored");
    protNoWrite_a: assert property (@(posedge linkClock) disable iff (!rst_n)
        $changed(stopToggle) |-> !protLink)
        else $error("write cycle started under protection");

    cWrite_c: cover property (@(posedge clock) disable iff (!rst_n) $rose(writeBusy));
    cRead_c:  cover property (@(posedge linkClock) disable iff (!rst_n) state == ST_RACK ##1 state == ST_RDATA);
    cPage_c:  cover property (@(posedge linkClock) disable iff (!rst_n) state == ST_WDATA_ACK ##9 state == ST_WDATA_ACK);
endmodule

// file: hdl/eeprom_pkg.sv
// package: constants, types and behaviour overview for the two-wire eeprom slave
// Overview of operation
// - data line changes only while clock low; changes with clock high mean start/stop
// - data falling while clock high is a start; master starts every command
// - data rising while clock high is a stop; stop after read enters standby
// - bytes are eight bits; device pulls data low on ninth clock to acknowledge
// - sample incoming bits on rising clock, change outgoing bits after falling clock
// - standby at power-up and after stop once any write cycle finished
// - respond only when upper four address bits equal the device-type code
// - next three bits match zero or serve as page-select depending on variant
// - page-select bits form top bits of word address above the address byte
// - word address is 8, 9, 10 or 11 bits by variant
// - address byte lsb one means read, zero means write
// - match is acknowledged; mismatch gets no acknowledge and the rest is ignored
// - byte write: ack device byte, word address, data; stop starts write cycle
// - during write cycle ignore the bus, no acknowledge; finish within 3 ms
// - page write up to 8 or 16 bytes, each acknowledged, ended by stop
// - only low three or four address bits increment, wrapping inside the page
// - polling during write cycle is acknowledged only after the cycle ends
// - address counter holds last accessed address plus one between operations
// - reads wrap at the array end, writes wrap inside the page
// - current address read sends the byte at the counter, master no-acks, stops
// - write-protect high blocks all writes; reads still work
// - random read is dummy write of address, repeated start, then read
// - master ack after read byte advances address and sends next byte
package eeprom_pkg;

    localparam int          VARIANT_KBIT   = 16;
    localparam int          ADDR_W         = 11;
    localparam int          PAGE_BITS      = (VARIANT_KBIT == 2) ? 3 : 4;
    localparam int          PAGE_SEL_BITS  = ADDR_W - 8;
    localparam int          DEPTH          = 1 << ADDR_W;
    localparam logic [3:0]  DEVICE_TYPE    = 4'ha;
    localparam logic [2:0]  BIT_COUNT_LAST = 3'h7;
    localparam logic [ADDR_W-1:0] ADDR_RESET = '0;

    localparam int CLOCK_MHZ                      = 100;
    localparam int SELF_TIMED_WRITE_DURATION_US   = 3000;
    localparam int SELF_TIMED_WRITE_CYCLES        = SELF_TIMED_WRITE_DURATION_US * CLOCK_MHZ;

    typedef enum {
        ST_IDLE,
        ST_DEV,
        ST_DEV_ACK,
        ST_WADDR,
        ST_WADDR_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RACK
    } link_state_e;

    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
    } byte_write_s;

endpackage

// file: hdl/level_sync.sv
// two flip-flop synchroniser for a level
`timescale 1ns/1ps
module level_sync
    import eeprom_pkg::*;
(
    // clocking
    input  wire logic clock,
    input  wire logic rst_n,
    // level
    input  wire logic in,
    output logic      out
);
    logic stage;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage <= 1'b0;
            out   <= 1'b0;
        end else begin
            stage <= in;
            out   <= stage;
        end
    end
endmodule

// file: hdl/write_timer.sv
// self-timed write cycle counter
`timescale 1ns/1ps
module write_timer
    import eeprom_pkg::*;
#(
    parameter int CYCLES = SELF_TIMED_WRITE_CYCLES
)(
    // clocking
    input  wire logic clock,
    input  wire logic rst_n,
    // control
    input  wire logic start,
    output logic      busy
);
    logic [31:0] count;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count <= 32'h0;
            busy  <= 1'b0;
        end else if (start && !busy) begin
            count <= 32'(CYCLES - 1);
            busy  <= 1'b1;
        end else if (busy) begin
            count <= count - 32'h1;
            busy  <= (count != 32'h0);
        end
    end

    writeTime_a: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(busy) |-> busy [*8])
        else $error("write cycle ended too early");
endmodule

// file: testbench/bus_master.sv
// two-wire bus master model driving the link clock and the data line
`timescale 1ns/1ps
module bus_master
    import eeprom_pkg::*;
(
    // link towards the device
    output logic      linkClock,
    output wire logic line,
    // device open-drain drive
    input  wire logic dataOut,
    input  wire logic dataOe
);
    logic sda;

    // pulled-up wire, low while either side pulls it
    assign line = sda & ~(dataOe & ~dataOut);

    // clock stands high outside frames
    initial begin
        linkClock = 1'b1;
        sda = 1'b1;
    end

    task automatic bitCycle(input logic b, output logic seen);
        #31 sda = b;
        #31.5 linkClock = 1'b1;
        #31 seen = line;
        #31.5 linkClock = 1'b0;
    endtask

    task automatic startCond();
        #31 sda = 1'b1;
        #31 linkClock = 1'b1;
        #31 sda = 1'b0;
        #31 linkClock = 1'b0;
    endtask

    task automatic stopCond();
        #31 sda = 1'b0;
        #31 linkClock = 1'b1;
        #31 sda = 1'b1;
    endtask

    task automatic recoverBus();
        logic seen;
        #31 linkClock = 1'b0;
        repeat (9) bitCycle(1'b1, seen);
        stopCond();
    endtask

    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic seen;
        for (int i = 7; i >= 0; i--) bitCycle(b[i], seen);
        // ninth clock released for the device answer
        bitCycle(1'b1, seen);
        ack = ~seen;
    endtask

    task automatic getByte(input logic ackIt, output logic [7:0] b);
        logic seen;
        for (int i = 7; i >= 0; i--) begin
            bitCycle(1'b1, seen);
            b[i] = seen;
        end
        bitCycle(~ackIt, seen);
    endtask
endmodule

// file: testbench/testbench.sv
// self-checking bench for the two-wire eeprom slave
`timescale 1ns/1ps
module testbench
    import eeprom_pkg::*;
;
    localparam int WCYC = 400;
    logic       clock;
    logic       rst_n;
    logic       writeProtect;
    wire        linkClock;
    wire        line;
    logic       dataOut;
    logic       dataOe;
    logic       writeBusy;
    logic       standby;
    logic       ack;
    logic       busySeen;
    logic [7:0] got [0:15];
    int         fail_count;
    int         tests_run;

    eeprom_slave #(.WRITE_CYCLES(WCYC)) i_eeprom_slave (
        .clock        (clock),
        .rst_n        (rst_n),
        .linkClock    (linkClock),
        .dataIn       (line),
        .dataOut      (dataOut),
        .dataOe       (dataOe),
        .writeProtect (writeProtect),
        .writeBusy    (writeBusy),
        .standby      (standby)
    );
    bus_master i_bus_master (
        .linkClock (linkClock),
        .line      (line),
        .dataOut   (dataOut),
        .dataOe    (dataOe)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [7:0] devByte(input logic [10:0] a, input logic rd);
        return {DEVICE_TYPE, a[10:8], rd};
    endfunction

    task automatic watchBusy();
        busySeen = 1'b0;
        repeat (40) begin
            @(posedge clock);
            busySeen = busySeen | (writeBusy === 1'b1);
        end
    endtask

    // acknowledge polling, bounded
    task automatic waitReady();
        for (int n = 0; n < 20; n++) begin
            i_bus_master.startCond();
            i_bus_master.sendByte(devByte(11'h000, 1'b0), ack);
            i_bus_master.stopCond();
            if (ack === 1'b1) return;
        end
        check("poll ack", 8'h01, 8'h00);
    endtask

    task automatic writeBytes(input logic [10:0] a, input logic [7:0] d, input int n);
        i_bus_master.startCond();
        i_bus_master.sendByte(devByte(a, 1'b0), ack);
        check("device ack", 8'h01, {7'h00, ack});
        i_bus_master.sendByte(a[7:0], ack);
        check("address ack", 8'h01, {7'h00, ack});
        for (int i = 0; i < n; i++) begin
            i_bus_master.sendByte(d + 8'(i), ack);
            check("data ack", 8'h01, {7'h00, ack});
        end
        i_bus_master.stopCond();
    endtask

    task automatic currentRead(input logic [10:0] a, input int n);
        i_bus_master.startCond();
        i_bus_master.sendByte(devByte(a, 1'b1), ack);
        check("read ack", 8'h01, {7'h00, ack});
        for (int i = 0; i < n; i++) i_bus_master.getByte(i < n - 1, got[i]);
        i_bus_master.stopCond();
    endtask

    task automatic readFrom(input logic [10:0] a, input int n);
        i_bus_master.startCond();
        i_bus_master.sendByte(devByte(a, 1'b0), ack);
        i_bus_master.sendByte(a[7:0], ack);
        currentRead(a, n);
    endtask

    task automatic testReset();
        check("standby", 8'h01, {7'h00, standby});
        check("busy", 8'h00, {7'h00, writeBusy});
        check("drive", 8'h00, {7'h00, dataOe});
    endtask

    task automatic testByteWrite();
        writeBytes(11'h5a3, 8'h3c, 1);
        watchBusy();
        check("write busy", 8'h01, {7'h00, busySeen});
        i_bus_master.startCond();
        i_bus_master.sendByte(devByte(11'h5a3, 1'b1), ack);
        i_bus_master.stopCond();
        check("busy poll", 8'h00, {7'h00, ack});
        waitReady();
        repeat (8) @(posedge clock);
        check("idle standby", 8'h01, {7'h00, standby});
        readFrom(11'h5a3, 1);
        check("byte read", 8'h3c, got[0]);
    endtask

    task automatic testPageWrap();
        writeBytes(11'h30e, 8'h10, 18);
        waitReady();
        readFrom(11'h300, 16);
        for (int k = 0; k < 16; k++) check("page byte", 8'h12 + 8'(k), got[k]);
    endtask

    task automatic testArrayWrap();
        writeBytes(11'h7ff, 8'hc5, 1);
        waitReady();
        writeBytes(11'h000, 8'h5c, 1);
        waitReady();
        readFrom(11'h7ff, 2);
        check("last byte", 8'hc5, got[0]);
        check("wrapped byte", 8'h5c, got[1]);
        readFrom(11'h7ff, 1);
        currentRead(11'h000, 1);
        check("current byte", 8'h5c, got[0]);
        repeat (8) @(posedge clock);
        check("read standby", 8'h01, {7'h00, standby});
    endtask

    task automatic testMismatch();
        i_bus_master.startCond();
        i_bus_master.sendByte({~DEVICE_TYPE, 4'h0}, ack);
        check("foreign ack", 8'h00, {7'h00, ack});
        i_bus_master.sendByte(8'h00, ack);
        check("ignored ack", 8'h00, {7'h00, ack});
        i_bus_master.stopCond();
    endtask

    task automatic testProtect();
        @(posedge clock);
        #1 writeProtect = 1'b1;
        repeat (4) @(posedge clock);
        writeBytes(11'h5a3, 8'hee, 1);
        watchBusy();
        check("protect busy", 8'h00, {7'h00, busySeen});
        readFrom(11'h5a3, 1);
        check("protect read", 8'h3c, got[0]);
        @(posedge clock);
        #1 writeProtect = 1'b0;
        repeat (4) @(posedge clock);
    endtask

    task automatic testAbort();
        i_bus_master.startCond();
        i_bus_master.sendByte(devByte(11'h5a3, 1'b0), ack);
        i_bus_master.sendByte(8'ha3, ack);
        repeat (4) i_bus_master.bitCycle(1'b0, ack);
        i_bus_master.stopCond();
        watchBusy();
        check("abort busy", 8'h00, {7'h00, busySeen});
        readFrom(11'h5a3, 1);
        check("abort read", 8'h3c, got[0]);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        writeProtect = 1'b0;
        fail_count = 0;
        tests_run = 0;
        repeat (6) @(posedge clock);
        #1 rst_n = 1'b1;
        testReset();
        i_bus_master.recoverBus();
        testByteWrite();
        testPageWrap();
        testArrayWrap();
        testMismatch();
        testProtect();
        testAbort();
        conclude();
    end

    // watchdog well beyond the expected run
    initial begin
        #400000;
        fail_count++;
        $display("[FAIL] watchdog expected finish seen timeout");
        conclude();
    end
endmodule
